// File: inc/xbp_pkg.sv
package xbp_pkg;
	// Data space is 64 KB; internal memory occupies the lowest 8,704 bytes
	localparam int          ADDR_W        = 16;
	localparam logic [15:0] INT_MEM_BYTES = 16'h2200;
	// Reset values of the data, wait-selection and counter registers
	localparam logic [7:0]  RST_BYTE      = 8'h00;
	localparam logic [1:0]  RST_WAIT      = 2'h0;
	localparam logic [2:0]  RST_CNT       = 3'h0;
	// Fixed phases of one external cycle without wait-states
	localparam logic [2:0]  ADDR_CYCLES   = 3'h1;
	localparam logic [2:0]  STROBE_CYCLES = 3'h1;

	typedef enum logic [2:0] {
		XBP_IDLE   = 3'b000,
		XBP_ADDR   = 3'b001,
		XBP_STROBE = 3'b010,
		XBP_WAIT   = 3'b011,
		XBP_END    = 3'b100
	} xbp_state_e;

	// True when an address lies above internal memory
	function automatic logic xbp_is_ext(input logic [15:0] a);
		return a >= INT_MEM_BYTES;
	endfunction : xbp_is_ext
endpackage : xbp_pkg

// File: design/xbp_wait_sel.sv
module xbp_wait_sel (
	// Address and sector configuration
	input  wire logic [15:0] addr,
	input  wire logic [15:0] sectorLimit,
	input  wire logic [1:0]  lowerWait,
	input  wire logic [1:0]  upperWait,
	// Chosen wait-state count
	output wire logic [1:0]  waitSel
);
	import xbp_pkg::*;

	// Addresses at or above the limit belong to the upper sector
	wire upperHit = addr >= sectorLimit;                 // [RL13]
	assign waitSel = upperHit ? upperWait : lowerWait;  // [RL14]
endmodule : xbp_wait_sel

// File: design/xbp_pin_mux.sv
module xbp_pin_mux #(
	parameter int W = 8
) (
	// Interface side
	input  wire logic [W-1:0] busOut,
	input  wire logic [W-1:0] busOe,
	input  wire logic         busOwn,
	// Port register side
	input  wire logic [W-1:0] portOut,
	input  wire logic [W-1:0] portDir,
	// Pin side
	output wire logic [W-1:0] pinOut,
	output wire logic [W-1:0] pinOe
);
	import xbp_pkg::*;

	// Interface overrides the direction register for the bits it owns
	assign pinOut = busOwn ? busOut : portOut;  // [RL1] [RL8] [RL16]
	assign pinOe  = busOwn ? busOe : portDir;   // [RL1] [RL8] [RL16]
endmodule : xbp_pin_mux

// File: design/xbp_ext_bus_port.sv
// How it works
// RL1: Enabled port owns its pins, ignores direction
// RL2: Drive bus only for addresses above internal; internal accesses here still drive address, write data and latch strobe
// RL3: Low lines multiplex address/data, high lines address
// RL4: Low address valid when latch strobe falls
// RL5: Latch strobe low throughout data transfer
// RL6: External latch transparent high, holds when low
// RL7: Internal access keeps read/write strobes inactive
// RL8: Disabled port reverts to normal port pins
// RL9: Disabled port never folds upper addresses internal; here a disabled port treats every address as internal
// RL10: Four wait settings, one without waits
// RL11: Each wait adds one clock period
// RL12: Trailing strobe pulse only if next accesses RAM
// RL13: Two sectors with configurable boundary
// RL14: Each sector has its own wait selection
// RL15: Software selects number of high address lines
// RL16: Released high lines output port register values
// RL17: Bus keeper holds last value when tri-stated
// RL18: Software enables or disables the bus keeper
// RL19: Pull-ups active when port register bits one
// RL20: Lowest 8,704 bytes never go external
// RL21: Strobes carry no fixed phase to crystal
// RL22: Read releases lines, captures at strobe rise
module xbp_ext_bus_port (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst,
	// Configuration
	input  wire logic                portEnable,
	input  wire logic                keeperEnable,
	input  wire logic [2:0]          highAddrMaskSel,
	input  wire logic [15:0]         sectorLimit,
	input  wire logic [1:0]          lowerSectorWait,
	input  wire logic [1:0]          upperSectorWait,
	// Ordinary port registers for both pin groups
	input  wire logic [7:0]          lowPortOut,
	input  wire logic [7:0]          lowPortDir,
	input  wire logic [7:0]          highPortOut,
	input  wire logic [7:0]          highPortDir,
	// CPU data-space request
	input  wire logic                reqValid,
	input  wire logic                reqWrite,
	input  wire logic [15:0]         reqAddr,
	input  wire logic [7:0]          reqWdata,
	input  wire logic                nextIsRam,
	output wire logic                reqReady,
	output logic                     rspValid,
	output logic [7:0]               rspRdata,
	output wire logic                extSelect,
	// Multiplexed address/data pins
	input  wire logic [7:0]          muxIn,
	output wire logic [7:0]          muxOut,
	output wire logic [7:0]          muxOe,
	output wire logic [7:0]          muxPullup,
	// High address pins
	output wire logic [7:0]          highOut,
	output wire logic [7:0]          highOe,
	// Strobes
	output logic                     latchStrobe,
	output logic                     readStrobeN,
	output logic                     writeStrobeN
);
	import xbp_pkg::*;

	xbp_state_e state_reg;
	xbp_state_e state_next;
	logic [2:0]  cnt_reg;
	logic [2:0]  cnt_next;
	logic [15:0] addr_reg;
	logic [7:0]  wdata_reg;
	logic        write_reg;
	logic        ext_reg;
	logic        nextRam_reg;
	logic [1:0]  wait_reg;
	logic [7:0]  keep_reg;

	// Decode of the incoming request
	wire        reqExt = portEnable && xbp_is_ext(reqAddr);  // [RL2] [RL20] [RL9]
	wire [1:0]  reqWait;
	wire        idle   = state_reg == XBP_IDLE;
	wire        start  = idle && reqValid;
	assign reqReady  = idle;
	assign extSelect = reqExt;

	xbp_wait_sel u_wait (
		.addr        (reqAddr),
		.sectorLimit (sectorLimit),
		.lowerWait   (lowerSectorWait),
		.upperWait   (upperSectorWait),
		.waitSel     (reqWait)
	);

	// Bus drive per phase: address in ADDR, data only on writes
	wire inAddr   = state_reg == XBP_ADDR;
	wire inData   = (state_reg == XBP_STROBE) || (state_reg == XBP_WAIT);
	wire driveLow = portEnable && (inAddr || (inData && write_reg));  // [RL22]
	wire [7:0] lowBus = inAddr ? addr_reg[7:0] : wdata_reg;            // [RL3]

	// Keeper holds the last driven value while released
	wire [7:0] lowOutInt = driveLow ? lowBus : keep_reg;               // [RL17]
	wire [7:0] lowOeInt  = driveLow ? 8'hff : 8'h00;

	// Mask frees the top high lines back to the port
	wire [7:0] highOwn = portEnable ? (8'hff >> highAddrMaskSel) : 8'h00;  // [RL15]

	xbp_pin_mux #(.W(8)) u_low (
		.busOut  (lowOutInt),
		.busOe   (lowOeInt),
		.busOwn  (portEnable),
		.portOut (lowPortOut),
		.portDir (lowPortDir),
		.pinOut  (muxOut),
		.pinOe   (muxOe)
	);

	// Per-bit ownership of the high lines
	genvar gi;
	for (gi = 0; gi < 8; gi++) begin : g_high
		xbp_pin_mux #(.W(1)) u_hi (
			.busOut  (addr_reg[8+gi]),
			.busOe   (1'b1),
			.busOwn  (highOwn[gi]),
			.portOut (highPortOut[gi]),
			.portDir (highPortDir[gi]),
			.pinOut  (highOut[gi]),
			.pinOe   (highOe[gi])
		);
	end

	// Pull-ups follow the port register regardless of mode
	assign muxPullup = lowPortOut;  // [RL19]

	// Sequencer: ADDR, STROBE, optional WAIT cycles, END
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		unique case (state_reg)
			XBP_IDLE:   if (reqValid) state_next = XBP_ADDR;
			XBP_ADDR:   state_next = XBP_STROBE;
			XBP_STROBE: begin
				if (wait_reg != RST_WAIT) begin
					state_next = XBP_WAIT;
					cnt_next   = {1'b0, wait_reg};  // [RL10] [RL11]
				end else begin
					state_next = XBP_END;
				end
			end
			XBP_WAIT: begin
				cnt_next = cnt_reg - 3'h1;          // [RL11]
				if (cnt_reg == ADDR_CYCLES) state_next = XBP_END;
			end
			XBP_END:    state_next = XBP_IDLE;
			default:    state_next = XBP_IDLE;
		endcase
	end

	// Strobe levels decided from next state so pins come from flops
	wire nAddr   = state_next == XBP_ADDR;
	wire nData   = (state_next == XBP_STROBE) || (state_next == XBP_WAIT);
	wire nEnd    = state_next == XBP_END;
	wire extNext = start ? reqExt : ext_reg;
	wire wrNext  = start ? reqWrite : write_reg;
	// Trailing pulse in the end period only if the next instruction uses RAM
	wire aleNext = portEnable && (nAddr || (nEnd && nextRam_reg));  // [RL4] [RL5] [RL12]
	wire strobeOn = nData && extNext;                               // [RL7] [RL2]
	// Capture on the read strobe's rising edge, at the end of data phase
	wire readDone = inData && !write_reg && ext_reg && !nData;      // [RL22]

	// State and request capture
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg   <= XBP_IDLE;
			cnt_reg     <= RST_CNT;
			addr_reg    <= 16'h0000;
			wdata_reg   <= RST_BYTE;
			write_reg   <= 1'b0;
			ext_reg     <= 1'b0;
			nextRam_reg <= 1'b0;
			wait_reg    <= RST_WAIT;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			if (start) begin
				addr_reg    <= reqAddr;
				wdata_reg   <= reqWdata;
				write_reg   <= reqWrite;
				ext_reg     <= reqExt;
				nextRam_reg <= nextIsRam;
				wait_reg    <= reqExt ? reqWait : RST_WAIT;  // [RL14]
			end
		end
	end

	// Strobe registers; no link clock, so timing is purely internal  [RL21]
	always_ff @(posedge clk) begin
		if (rst) begin
			latchStrobe  <= 1'b0;
			readStrobeN  <= 1'b1;
			writeStrobeN <= 1'b1;
		end else begin
			latchStrobe  <= aleNext;
			readStrobeN  <= !(strobeOn && !wrNext);
			writeStrobeN <= !(strobeOn && wrNext);
		end
	end

	// Keeper and read data; keeper disabled lets released lines follow port
	always_ff @(posedge clk) begin
		if (rst) begin
			keep_reg <= RST_BYTE;
			rspValid <= 1'b0;
			rspRdata <= RST_BYTE;
		end else begin
			if (!keeperEnable) keep_reg <= lowPortOut;      // [RL18]
			else if (driveLow) keep_reg <= lowBus;          // [RL17]
			else if (inData) keep_reg <= muxIn;
			rspValid <= readDone || (state_reg == XBP_END && !ext_reg && !write_reg);
			if (readDone) rspRdata <= muxIn;                // [RL22]
		end
	end
endmodule : xbp_ext_bus_port

// File: tb/xbp_ext_bus_port_props.sv
module xbp_ext_bus_port_props
	import xbp_pkg::*;
(
	input wire logic        clk, rst, portEnable, reqValid, reqReady, nextIsRam, extSelect,
	input wire logic        latchStrobe, readStrobeN, writeStrobeN,
	input wire logic [2:0]  highAddrMaskSel,
	input wire logic [1:0]  lowerSectorWait, upperSectorWait,
	input wire logic [15:0] sectorLimit, reqAddr,
	input wire logic [7:0]  reqWdata, lowPortOut, highPortOut, highPortDir,
	input wire logic [7:0]  muxOut, muxOe, muxPullup, highOut, highOe
);
	logic [1:0]  wCap;
	logic [2:0]  lowCnt;
	logic        nrCap;
	logic [7:0]  wdCap;
	logic [15:0] aCap;
	wire  [7:0]  hiMask = 8'hff >> highAddrMaskSel;
	// Remember what was taken, and count strobe-low cycles to measure waits
	always_ff @(posedge clk) begin
		if (reqValid && reqReady) begin
			wCap  <= (reqAddr >= sectorLimit) ? upperSectorWait : lowerSectorWait;
			nrCap <= nextIsRam;
			wdCap <= reqWdata;
			aCap  <= reqAddr;
		end
		lowCnt <= (readStrobeN && writeStrobeN) ? 3'h0 : lowCnt + 3'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence sTake; reqValid && reqReady && extSelect; endsequence
	sequence sEnd; $rose(readStrobeN && writeStrobeN); endsequence
	AST_ADDR_PHASE: assert property (sTake |=> latchStrobe && muxOe == 8'hff &&
		muxOut == aCap[7:0] && (highOut & hiMask) == (aCap[15:8] & hiMask))
		else $error("address phase wrong");
	AST_WAIT_LEN: assert property (sEnd |-> lowCnt == {1'b0, wCap} + 3'h1)
		else $error("strobe length wrong");
	AST_TRAIL_ALE: assert property (sEnd |-> latchStrobe == nrCap)
		else $error("trailing latch pulse wrong");
	AST_ALE_LOW: assert property (!(readStrobeN && writeStrobeN) |-> !latchStrobe)
		else $error("latch strobe high in data phase");
	AST_INT_QUIET: assert property (reqValid && reqReady && !extSelect |=>
		(readStrobeN && writeStrobeN)[*3]) else $error("strobe on internal access");
	AST_READ_REL: assert property (!readStrobeN |-> muxOe == 8'h00)
		else $error("lines driven during read");
	AST_WRITE_DATA: assert property (!writeStrobeN |-> muxOe == 8'hff && muxOut == wdCap)
		else $error("write data wrong");
	AST_SELECT: assert property (extSelect == (portEnable && reqAddr >= INT_MEM_BYTES))
		else $error("select decode wrong");
	AST_DISABLED: assert property (!portEnable |-> readStrobeN && writeStrobeN &&
		highOut == highPortOut && highOe == highPortDir) else $error("disabled pins wrong");
	AST_HIGH_MASK: assert property (portEnable |-> (highOe & hiMask) == hiMask &&
		((highOut ^ highPortOut) & ~hiMask) == 8'h00) else $error("high mask wrong");
	AST_PULLUP: assert property (muxPullup == lowPortOut)
		else $error("pull-up wrong");
endmodule : xbp_ext_bus_port_props

bind xbp_ext_bus_port xbp_ext_bus_port_props u_props (.*);

// File: tb/xbp_mem_model.sv
module xbp_mem_model (
	input wire logic       clk, latchStrobe, readStrobeN, writeStrobeN,
	input wire logic [7:0] muxOut, muxOe, muxPullup, highOut,
	output wire logic [7:0] muxIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:65535];
	logic [7:0] lowLat;
	logic [7:0] lastV = 8'h00;
	// Latch follows the lines while the strobe is high and holds once it falls.
	// Sampled at the clock so the falling strobe and the bus turning to data
	// at the same edge cannot race; this stands in for the latch hold time.
	always @(posedge clk) begin
		if (latchStrobe) lowLat <= muxIn;
	end
	// Data only while read is low; a released line shows pull-up or a moving value
	assign muxIn = (muxOe & muxOut) | (~muxOe & (readStrobeN ?
		(muxPullup | ~lastV) : mem[{highOut, lowLat}]));
	// Store while write is low; the last sample before the rise wins
	always @(posedge clk) begin
		lastV <= muxIn;
		if (!writeStrobeN) mem[{highOut, lowLat}] <= muxIn;
	end
endmodule : xbp_mem_model

// File: tb/xbp_ext_bus_port_tb_top.sv
module xbp_ext_bus_port_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, portEnable = 1, keeperEnable = 1, reqValid = 0, reqWrite = 0;
	logic nextIsRam = 0, reqReady, rspValid, extSelect, latchStrobe, readStrobeN, writeStrobeN;
	logic [2:0]  highAddrMaskSel = 3'h0;
	logic [1:0]  lowerSectorWait = 2'h0, upperSectorWait = 2'h0;
	logic [15:0] sectorLimit = 16'h8000, reqAddr = 16'h0000;
	logic [7:0]  lowPortOut = 8'h0f, lowPortDir = 8'h00, highPortOut = 8'h00, highPortDir = 8'hff;
	logic [7:0]  reqWdata = 8'h00, rspRdata, muxIn, muxOut, muxOe, muxPullup, highOut, highOe;
	int n_fail = 0, cmp_count = 0, cyc;
	xbp_ext_bus_port dut (.*);
	xbp_mem_model farMem (.*);
	// Free-running system clock
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One byte access; request held until taken, cyc counts cycles to ready again
	task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int k;
		reqValid = 1;
		reqWrite = wr;
		reqAddr = a;
		reqWdata = d;
		nextIsRam = a[0];
		q = 8'h00;
		k = 0;
		while (reqReady !== 1'b1 && k < 50) begin
			@(posedge clk);
			#5;
			k++;
		end
		@(posedge clk);
		#5;
		reqValid = 0;
		cyc = 0;
		do begin
			@(posedge clk);
			#5;
			cyc++;
			if (rspValid === 1'b1) q = rspRdata;
		end while (reqReady !== 1'b1 && cyc < 50);
	endtask : acc
	// Sectors carry opposite waits; each wait must add exactly one cycle
	task automatic sc_waits;
		logic [7:0] q;
		int base;
		for (int w = 0; w < 4; w++) begin
			lowerSectorWait = 2'(w);
			upperSectorWait = 2'(3 - w);
			acc(1'b1, 16'h3000 + 16'(w), 8'h30 + 8'(w), q);
			if (w == 0) base = cyc;
			chk(16'(cyc), 16'(base + w));
			acc(1'b1, 16'h9000 + 16'(w), 8'h90 + 8'(w), q);
			chk(16'(cyc), 16'(base + 3 - w));
			acc(1'b0, 16'h3000 + 16'(w), 8'h00, q);
			chk(16'(q), 16'h0030 + 16'(w));
			acc(1'b0, 16'h9000 + 16'(w), 8'h00, q);
			chk(16'(q), 16'h0090 + 16'(w));
		end
	endtask : sc_waits
	// Internal boundary, then a disabled port must leave external memory alone
	task automatic sc_bounds;
		logic [7:0] q;
		reqAddr = 16'h21ff;
		#1 chk(16'(extSelect), 16'h0000);
		reqAddr = 16'h2200;
		#1 chk(16'(extSelect), 16'h0001);
		acc(1'b1, 16'h21ff, 8'h11, q);
		portEnable = 0;
		#1 chk({muxOut, muxOe}, 16'h0f00);
		acc(1'b1, 16'h3000, 8'hee, q);
		portEnable = 1;
		acc(1'b0, 16'h3000, 8'h00, q);
		chk(16'(q), 16'h0030);
	endtask : sc_bounds
	// Released top lines show the port value, so 0x4001 reaches 0x0001
	task automatic sc_mask;
		logic [7:0] q;
		highAddrMaskSel = 3'h2;
		acc(1'b1, 16'h4001, 8'haa, q);
		highAddrMaskSel = 3'h0;
		acc(1'b1, 16'h4001, 8'h55, q);
		acc(1'b0, 16'h4001, 8'h00, q);
		chk(16'(q), 16'h0055);
		highAddrMaskSel = 3'h2;
		acc(1'b0, 16'h4001, 8'h00, q);
		chk(16'(q), 16'h00aa);
	endtask : sc_mask
	task automatic tally_and_finish;
		if (n_fail == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	// Main sequence after a 12-cycle reset
	initial begin
		repeat (12) @(posedge clk);
		#5;
		rst = 0;
		sc_waits();
		sc_bounds();
		sc_mask();
		tally_and_finish();
	end
	// 23 accesses of under 10 cycles each; over sixteen times that is a hang
	initial begin
		#200000;
		n_fail++;
		tally_and_finish();
	end
endmodule : xbp_ext_bus_port_tb_top
